// File: inc/interlock_defs.svh
// constants for the refueling interlock logic
// Function
// - channel all-rods-in only when every rod fully-inserted switch is closed.
// - two all-rods-in channels; combined all-rods-in needs both.
// - in refuel, refuse selecting a rod while another rod is out.
// - refuse a request that selects two or more rods at once.
// - in refuel, stop loaded platform over core while any rod withdrawn.
// - rod block when platform near core and hoist fuel-loaded together.
// - while rod block is active, refuse every withdrawal command.
// - equipment interlock acts by dropping the equipment power relay drive.
// - either platform position switch open means platform near the core.
// - hoist load switch open means fuel loaded on the hoist.
// - two trip channels from one sensor; channel power loss counts tripped.
// - withdrawal allowed only when A and B halves agree.
// - loss of shared logic supply stops all rod motion.
// - block held when either channel lacks permissive; channels independent.
`ifndef INTERLOCK_DEFS_SVH
`define INTERLOCK_DEFS_SVH

`define ROD_COUNT 8
`define ROD_IDX_W 3
`define WARMUP_CYCLES 3'h3
`define WARMUP_W 3

`define ADDR_STATUS 8'h00
`define ADDR_IRQ_STAT 8'h04
`define ADDR_IRQ_MASK 8'h08
`define ADDR_CONTROL 8'h0C
`define ADDR_REFUSE 8'h10

`define EV_W 4
`define EV_ROD_BLOCK 0
`define EV_EQUIP_TRIP 1
`define EV_CMD_REFUSED 2
`define EV_MISMATCH 3

`define CTRL_RESET 1'h0

`endif

// File: inc/interlock_pkg.sv
// types for the refueling interlock logic
package interlock_pkg;
    typedef enum logic [1:0] {
        WARMUP,
        RUN
    } phase_t;

    typedef struct packed {
        logic [7:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
        logic cyc;
        logic stb;
    } wb_req_t;

    typedef struct packed {
        logic [7:0] rod_in_a;      // fully-inserted switches, channel a
        logic [7:0] rod_in_b;      // fully-inserted switches, channel b
        logic [1:0] plat_sw;       // platform switches, closed = clear
        logic hoist_trip_a;        // trip unit a closed = unloaded
        logic hoist_trip_b;
        logic pwr_ok_a;            // trip unit power good
        logic pwr_ok_b;
        logic logic_pwr_ok;        // shared logic supply good
        logic refuel_mode;
    } sense_t;

    typedef struct packed {
        phase_t phase;
        logic [2:0] warm_cnt;
        sense_t s;
        logic rod_block;
        logic equip_pwr;
        logic wd_grant;
        logic [7:0] wd_sel;
        logic [7:0] refuse_cnt;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic force_block;
        logic ack;
        logic [31:0] rdat;
    } state_t;
endpackage : interlock_pkg

// File: core/refuel_interlock_logic.sv
// refueling interlock: rod block and platform power relay, wishbone regs
`timescale 1ns/1ps
`include "interlock_defs.svh"

module refuel_interlock_logic (
    input wire logic clk_i,                              // 10 MHz clock
    input wire logic rst_i,                              // sync reset, high
    input wire interlock_pkg::sense_t sense_i,           // field contacts
    input wire logic [7:0] wd_sel_i,                     // withdraw select
    input wire logic wd_req_i,                           // withdraw request
    input wire logic [7:0] half_b_sel_i,                 // half b selection
    input wire interlock_pkg::wb_req_t wb_i,             // wishbone request
    output logic [31:0] wb_dat_o,                        // read data
    output logic wb_ack_o,                               // acknowledge
    output logic rod_block_o,                            // rod block, high
    output logic equip_pwr_o,                            // relay drive
    output logic wd_grant_o,                             // withdraw issued
    output logic [7:0] wd_rod_o,                         // rod given move
    output logic irq_o                                   // interrupt
);
    // ****************************************
    // input synchronisers
    // ****************************************
    interlock_pkg::sense_t sync1_reg;
    interlock_pkg::sense_t sync2_reg;
    logic [7:0] sel1_reg;
    logic [7:0] sel2_reg;
    logic req1_reg;
    logic req2_reg;
    logic [7:0] hb1_reg;
    logic [7:0] hb2_reg;
    // third stage keeps select in step with the sensed-state stage
    logic [7:0] sel3_reg;
    logic req3_reg;
    logic [7:0] hb3_reg;

    always_ff @(posedge clk_i) begin
        sync1_reg <= sense_i;
        sync2_reg <= sync1_reg;
        sel1_reg <= wd_sel_i;
        sel2_reg <= sel1_reg;
        req1_reg <= wd_req_i;
        req2_reg <= req1_reg;
        hb1_reg <= half_b_sel_i;
        hb2_reg <= hb1_reg;
        sel3_reg <= sel2_reg;
        req3_reg <= req2_reg;
        hb3_reg <= hb2_reg;
    end

    function automatic logic one_hot(input logic [7:0] v);
        return (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
    endfunction : one_hot

    // ****************************************
    // state
    // ****************************************
    interlock_pkg::state_t st_reg;
    interlock_pkg::state_t st_next;

    logic all_in_a;
    logic all_in_b;
    logic all_in;
    logic near_core;
    logic load_a;
    logic load_b;
    logic block_a;
    logic block_b;
    logic blk;
    logic eq_ok;
    logic sel_ok;
    logic agree;
    logic refuse;
    logic [3:0] ev;
    logic wr;
    logic rd;

    always_comb begin
        st_next = st_reg;
        all_in_a = &st_reg.s.rod_in_a;
        all_in_b = &st_reg.s.rod_in_b;
        all_in = all_in_a && all_in_b;
        near_core = ~&st_reg.s.plat_sw;
        // unpowered trip unit reads as loaded
        load_a = !st_reg.s.hoist_trip_a || !st_reg.s.pwr_ok_a;
        load_b = !st_reg.s.hoist_trip_b || !st_reg.s.pwr_ok_b;
        block_a = near_core && load_a;
        block_b = near_core && load_b;
        // either channel alone can block
        blk = block_a || block_b || st_reg.force_block
            || !st_reg.s.logic_pwr_ok
            || st_reg.phase != interlock_pkg::RUN;
        eq_ok = !(st_reg.s.refuel_mode && !all_in
                  && (load_a || load_b))
                && st_reg.s.logic_pwr_ok
                && st_reg.phase == interlock_pkg::RUN;
        sel_ok = one_hot(sel3_reg);
        // in refuel a new rod is refused unless all rods are home
        if (st_reg.s.refuel_mode && !all_in)
            sel_ok = 1'b0;
        agree = (sel3_reg == hb3_reg);
        refuse = req3_reg && (blk || !sel_ok || !agree);

        st_next.rod_block = blk;
        st_next.equip_pwr = eq_ok;
        st_next.wd_grant = req3_reg && !refuse;
        st_next.wd_sel = (req3_reg && !refuse) ? sel3_reg : 8'h00;
        if (refuse)
            st_next.refuse_cnt = st_reg.refuse_cnt + 8'h01;

        st_next.s = sync2_reg;
        case (st_reg.phase)
            interlock_pkg::WARMUP: begin
                if (st_reg.warm_cnt == `WARMUP_CYCLES)
                    st_next.phase = interlock_pkg::RUN;
                else
                    st_next.warm_cnt = st_reg.warm_cnt + 3'h1;
            end
            interlock_pkg::RUN: begin
            end
            default: st_next.phase = interlock_pkg::WARMUP;
        endcase

        // ****************************************
        // wishbone slave, registered ack, one wait state
        // ****************************************
        // write lands at the edge where the master sees ack
        wr = wb_i.cyc && wb_i.stb && wb_i.we && st_reg.ack;
        rd = wb_i.cyc && wb_i.stb && !wb_i.we && !st_reg.ack;
        st_next.ack = wb_i.cyc && wb_i.stb && !st_reg.ack;
        st_next.rdat = 32'h0000_0000;
        if (rd) begin
            case (wb_i.adr)
                `ADDR_STATUS: st_next.rdat = {24'h000000, all_in_a,
                    all_in_b, near_core, load_a, load_b,
                    st_reg.rod_block, st_reg.equip_pwr,
                    st_reg.phase == interlock_pkg::RUN};
                `ADDR_IRQ_STAT: st_next.rdat = {28'h0000000, st_reg.irq_stat};
                `ADDR_IRQ_MASK: st_next.rdat = {28'h0000000, st_reg.irq_mask};
                `ADDR_CONTROL: st_next.rdat = {31'h00000000,
                                               st_reg.force_block};
                `ADDR_REFUSE: st_next.rdat = {24'h000000, st_reg.refuse_cnt};
                default: st_next.rdat = 32'h0000_0000;
            endcase
        end

        ev = 4'h0;
        ev[`EV_ROD_BLOCK] = blk && !st_reg.rod_block;
        ev[`EV_EQUIP_TRIP] = !eq_ok && st_reg.equip_pwr;
        ev[`EV_CMD_REFUSED] = refuse;
        ev[`EV_MISMATCH] = req3_reg && !agree;
        // a new event wins over a write-one clear
        if (wr && wb_i.sel[0]) begin
            case (wb_i.adr)
                `ADDR_IRQ_STAT: st_next.irq_stat =
                    st_reg.irq_stat & ~wb_i.dat[3:0];
                `ADDR_IRQ_MASK: st_next.irq_mask = wb_i.dat[3:0];
                `ADDR_CONTROL: st_next.force_block = wb_i.dat[0];
                default: ;
            endcase
        end
        st_next.irq_stat = st_next.irq_stat | ev;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
            st_reg.phase <= interlock_pkg::WARMUP;
            st_reg.rod_block <= 1'b1;
            st_reg.equip_pwr <= 1'b0;
            st_reg.force_block <= `CTRL_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_dat_o = st_reg.rdat;
    assign wb_ack_o = st_reg.ack;
    assign rod_block_o = st_reg.rod_block;
    assign equip_pwr_o = st_reg.equip_pwr;
    assign wd_grant_o = st_reg.wd_grant;
    assign wd_rod_o = st_reg.wd_sel;
    assign irq_o = |(st_reg.irq_stat & st_reg.irq_mask);
endmodule : refuel_interlock_logic

// File: bench/refuel_field_model.sv
// field contact model: rods, platform, hoist, supply
`timescale 1ns/1ps
module refuel_field_model (
    input wire logic [7:0] rods_out_i, // rods withdrawn
    input wire logic near_i, // platform near core
    input wire logic loaded_i, // fuel on hoist
    input wire logic supply_i, // logic supply good
    input wire logic refuel_i, // refuel mode
    output interlock_pkg::sense_t sense_o // contact levels
);
    assign sense_o.rod_in_a = ~rods_out_i;
    assign sense_o.rod_in_b = ~rods_out_i;
    assign sense_o.plat_sw = near_i ? 2'h2 : 2'h3;
    assign sense_o.hoist_trip_a = ~loaded_i;
    assign sense_o.hoist_trip_b = ~loaded_i;
    assign sense_o.pwr_ok_a = 1'h1;
    assign sense_o.pwr_ok_b = 1'h1;
    assign sense_o.logic_pwr_ok = supply_i;
    assign sense_o.refuel_mode = refuel_i;
endmodule : refuel_field_model

// File: bench/refuel_interlock_logic_sva.sv
// port assertions for the refueling interlock
`timescale 1ns/1ps
module refuel_interlock_logic_sva (
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire interlock_pkg::sense_t sense_i, // contacts
    input wire logic [7:0] wd_sel_i, // select
    input wire logic [7:0] half_b_sel_i, // half b select
    input wire logic wd_grant_o, // grant
    input wire logic [7:0] wd_rod_o, // granted rod
    input wire logic rod_block_o, // block
    input wire logic equip_pwr_o // relay
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic near, loaded, out;
    // outputs trail the pins by four edges
    assign near = ~&sense_i.plat_sw;
    assign loaded = ~sense_i.hoist_trip_a | ~sense_i.hoist_trip_b;
    assign out = ~&(sense_i.rod_in_a & sense_i.rod_in_b);
    sequence s_safe; rod_block_o && !equip_pwr_o; endsequence
    property p_warm; $fell(rst_i) |-> s_safe [*4]; endproperty
    property p_block; $past(near && loaded, 4) |-> rod_block_o; endproperty
    property p_refuse; wd_grant_o |-> !rod_block_o; endproperty
    property p_onehot; wd_grant_o |-> $onehot(wd_rod_o); endproperty
    property p_idle; !wd_grant_o |-> wd_rod_o == 8'h00; endproperty
    property p_pair; $past(wd_sel_i != half_b_sel_i, 4) |-> !wd_grant_o;
    endproperty
    property p_supply; $past(!sense_i.logic_pwr_ok, 4) |-> s_safe;
    endproperty
    property p_equip;
        $past(sense_i.refuel_mode && loaded && out, 4) |-> !equip_pwr_o;
    endproperty
    a_warm: assert property (p_warm) else $error("not safe after reset");
    a_block: assert property (p_block) else $error("no rod block");
    a_refuse: assert property (p_refuse) else $error("grant in block");
    a_onehot: assert property (p_onehot) else $error("multi rod grant");
    a_idle: assert property (p_idle) else $error("stray rod");
    a_pair: assert property (p_pair) else $error("halves differ");
    a_supply: assert property (p_supply) else $error("supply loss");
    a_equip: assert property (p_equip) else $error("relay on");
endmodule : refuel_interlock_logic_sva
bind refuel_interlock_logic refuel_interlock_logic_sva sva_i (.clk_i(clk_i),
    .rst_i(rst_i), .sense_i(sense_i), .wd_sel_i(wd_sel_i),
    .half_b_sel_i(half_b_sel_i), .wd_grant_o(wd_grant_o),
    .wd_rod_o(wd_rod_o), .rod_block_o(rod_block_o), .equip_pwr_o(equip_pwr_o));

// File: bench/refuel_interlock_logic_tb.sv
// self-checking bench for the refueling interlock
`timescale 1ns/1ps
module refuel_interlock_logic_tb;
    logic clk_i = 1'h0, rst_i = 1'h1, near = 1'h0, loaded = 1'h0;
    logic supply = 1'h1, refuel = 1'h1, req = 1'h0, ack, blk, pwr, grant, irq;
    logic [7:0] rods = 8'h00, sel = 8'h01, half_b = 8'h01, rod;
    logic [31:0] dat, rd;
    interlock_pkg::sense_t sense;
    interlock_pkg::wb_req_t wb = 47'h0;
    int errors = 0, checks_done = 0;
    refuel_field_model refuel_field_model_i (.rods_out_i(rods),
        .near_i(near), .loaded_i(loaded), .supply_i(supply),
        .refuel_i(refuel), .sense_o(sense));
    refuel_interlock_logic refuel_interlock_logic_i (.clk_i(clk_i),
        .rst_i(rst_i), .sense_i(sense), .wd_sel_i(sel), .wd_req_i(req),
        .half_b_sel_i(half_b), .wb_i(wb), .wb_dat_o(dat), .wb_ack_o(ack),
        .rod_block_o(blk), .equip_pwr_o(pwr), .wd_grant_o(grant),
        .wd_rod_o(rod), .irq_o(irq));
    initial forever #50 clk_i = ~clk_i;
    task automatic chk(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // fixed wait: four edges of latency plus warm margin
    task automatic settle; repeat (8) @(posedge clk_i); endtask : settle
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        wb <= {a, d, 4'hF, w, 2'h3};
        do begin @(posedge clk_i); n++; end while (ack !== 1'h1 && n < 20);
        rd = dat;
        chk("ack", ack, 1'h1);
        wb <= 47'h0;
        @(posedge clk_i);
    endtask : bus
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    task automatic t_interlock;
        chk("blk", blk, 1'h1); chk("pwr", pwr, 1'h0);
        settle; settle;
        chk("blk", blk, 1'h0); chk("pwr", pwr, 1'h1);
        near <= 1'h1; loaded <= 1'h1; req <= 1'h1; settle;
        chk("blk", blk, 1'h1); chk("grant", grant, 1'h0);
        near <= 1'h0; settle;
        chk("grant", grant, 1'h1); chk("rod", rod, 8'h01);
        loaded <= 1'h0; sel <= 8'h03; half_b <= 8'h03; settle;
        chk("grant", grant, 1'h0);
        sel <= 8'h04; half_b <= 8'h08; settle;
        chk("grant", grant, 1'h0);
        half_b <= 8'h04; rods <= 8'h01; settle;
        chk("grant", grant, 1'h0);
        rods <= 8'h00; settle;
        chk("rod", rod, 8'h04);
        req <= 1'h0; rods <= 8'h10; loaded <= 1'h1; settle;
        chk("pwr", pwr, 1'h0);
        rods <= 8'h00; loaded <= 1'h0; supply <= 1'h0; settle;
        chk("blk", blk, 1'h1); chk("pwr", pwr, 1'h0);
        supply <= 1'h1; settle;
        $display("interlock test done");
    endtask : t_interlock
    task automatic t_regs;
        bus(8'h0C, 1'h1, 32'h1); settle;
        chk("force blk", blk, 1'h1);
        bus(8'h0C, 1'h1, 32'h0); settle;
        chk("force off", blk, 1'h0);
        bus(8'h08, 1'h1, 32'h1); bus(8'h04, 1'h1, 32'hF);
        chk("irq", irq, 1'h0);
        near <= 1'h1; loaded <= 1'h1; settle;
        chk("irq", irq, 1'h1);
        bus(8'h00, 1'h0, 32'h0); chk("status", rd[2], 1'h1);
        bus(8'h04, 1'h1, 32'h1); chk("irq", irq, 1'h0);
        bus(8'h40, 1'h0, 32'h0); chk("unmapped", rd, 32'h0);
        $display("register test done");
    endtask : t_regs
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        t_interlock;
        t_regs;
        tally_and_finish;
    end
    initial begin
        #100000;
        errors++;
        tally_and_finish;
    end
endmodule : refuel_interlock_logic_tb
